// [shared/aicd_pkg.sv]
/*
  Shared constants and types for the audio input capture and downsampler block.
  Assumes a single 125 MHz system clock and the plain register port of the top module.
*/
package aicd_pkg;
  // geometry
  localparam int I2S_LINES = 4;
  localparam int CHANNELS = 8;
  localparam int WORD_BITS = 24;
  localparam int DSD_PACKET_BITS = 56;
  localparam int PIN_COUNT = 10;
  localparam int CNT_W = 8;

  // timing: one-bit audio clock made by the source
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int DSD_CLK_HZ = 2_882_000;
  localparam int DSD_FS_MULT = 64;
  localparam int DSD_CLK_CYCLES = SYS_CLK_HZ / DSD_CLK_HZ;

  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CSIN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MDIV = 8'h0C;

  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [3:0] CSIN_RESET = 4'h0;
  localparam logic [7:0] MDIV_RESET = 8'h05;

  // forced word length pattern for channel-status bits 35..33
  localparam logic [2:0] CS_FORCED_LEN = 3'h5;

  typedef enum logic [1:0] {
    MODE_I2S = 2'h0,
    MODE_HBR = 2'h1,
    MODE_DSD = 2'h2,
    MODE_SPDIF = 2'h3
  } aicd_mode_type;

  typedef enum logic [3:0] {
    RATE_32 = 4'h0, RATE_44 = 4'h1, RATE_48 = 4'h2, RATE_64 = 4'h3, RATE_88 = 4'h4,
    RATE_96 = 4'h5, RATE_128 = 4'h6, RATE_176 = 4'h7, RATE_192 = 4'h8
  } aicd_rate_type;

  typedef enum logic [2:0] {
    RATIO_128 = 3'h0, RATIO_192 = 3'h1, RATIO_256 = 3'h2, RATIO_384 = 3'h3,
    RATIO_512 = 3'h4, RATIO_768 = 3'h5, RATIO_1024 = 3'h6, RATIO_1152 = 3'h7
  } aicd_ratio_type;

  typedef enum logic [1:0] {
    DECIM_NONE = 2'h0,
    DECIM_HALF = 2'h1,
    DECIM_QUARTER = 2'h2
  } aicd_decim_type;

  // control register layout, msb first
  typedef struct packed {
    logic [2:0] spare;
    aicd_rate_type rate;
    aicd_ratio_type ratio;
    logic mclkExt;
    aicd_mode_type mode;
    aicd_decim_type decim;
    logic dsEn;
  } aicd_ctrl_type;

  // one captured audio word
  typedef struct packed {
    logic hbr;
    logic [2:0] chan;
    logic [WORD_BITS-1:0] data;
  } aicd_sample_type;
endpackage

// [rtl/aicd_pin_sync.sv]
/*
  Two-stage synchroniser with rising-edge detect for a group of pins.
  Assumes the pins are asynchronous to clk; edges are found after the second stage only.
*/
`timescale 1ns/100ps
`default_nettype none
module aicd_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [W-1:0] pinIn,
  // synchronised view
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
endmodule
`default_nettype wire

// [rtl/aicd_dsd_packer.sv]
/*
  Packs eight one-bit audio channels into 56-bit packets, one per channel FIFO.
  Assumes bitRise marks a synchronised rising edge of the one-bit audio clock.
*/
`timescale 1ns/100ps
`default_nettype none
module aicd_dsd_packer
  import aicd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bit stream
  input wire logic enable,
  input wire logic bitRise,
  input wire logic [CHANNELS-1:0] bits,
  // packets
  output logic [CHANNELS-1:0] wr_r,
  output logic [CHANNELS-1:0][DSD_PACKET_BITS-1:0] data_r
);
  logic [5:0] bitCnt_r;
  logic lastBit;

  assign lastBit = bitCnt_r == 6'(DSD_PACKET_BITS - 1);

  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      bitCnt_r <= '0;
    end else if (bitRise) begin
      bitCnt_r <= lastBit ? '0 : bitCnt_r + 6'h01;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : gChan
    logic [DSD_PACKET_BITS-2:0] shift_r;
    always_ff @(posedge clk) begin
      if (rst) begin
        shift_r <= '0;
        data_r[c] <= '0;
        wr_r[c] <= 1'b0;
      end else begin
        wr_r[c] <= 1'b0;
        if (enable && bitRise) begin
          shift_r <= {shift_r[DSD_PACKET_BITS-3:0], bits[c]};
          if (lastBit) begin
            data_r[c] <= {shift_r, bits[c]};
            wr_r[c] <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/aicd_capture.sv]
/*
  Audio input capture: I2S (PCM and high bit rate), one-bit audio packing, two-channel
  downsampler with channel-status word-length rewrite, and master audio clock selection.
  Assumes a 125 MHz mclk, pins asynchronous to it, and a one-cycle register port.
*/
// Overview of operation
// - four I2S data lines share bit clock and word select, eight PCM channels
// - the same I2S lines also carry split high bit-rate compressed streams
// - two-channel PCM may be decimated by two or four under register control
// - one-bit mode uses nine pins, eight channels, seven shared with I2S/S/PDIF
// - one-bit data sampled on clock rise, packed to 56 bits, one FIFO each
// - one-bit sampling info goes in the infoframe, not the channel status
// - internal master clock generator, external master clock usable when selected
// - accepted rates: 32, 44.1, 48, 64, 88.2, 96, 128, 176.4, 192 kHz
// - 64 and 128 kHz I2S PCM audio is decimated to 32 kHz before the link
// - master clock ratio 128..1152 fs; 512/768 up to 96k, 1024/1152 up to 48k
// - downsampler converts only 192/176.4 to 48/44.1 and 96/88.2 to 48/44.1
// - with downsampler on, word length reports the maximum for the max setting
// - with downsampler on, channel-status bits 35..33 are forced to 101
// - widened samples get zero low bits, audio value unchanged
// - bit 32 picks 20 or 24 bit maximum; bits 35..33 give the word length
// - an active-low asynchronous chip reset clears the whole capture logic
`timescale 1ns/100ps
`default_nettype none
module aicd_capture
  import aicd_pkg::*;
(
  // clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipRstN,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData_r,
  // audio pins
  input wire logic extMclkIn,
  input wire logic bitClkIn,
  input wire logic wordSelIn,
  input wire logic [I2S_LINES-1:0] serDataIn,
  input wire logic spdifIn,
  input wire logic dsdRight3In,
  input wire logic dsdLeft3In,
  // captured PCM and high bit-rate words
  output aicd_sample_type sample_r,
  output logic sampleValid_r,
  // one-bit audio packets
  output logic [CHANNELS-1:0] dsdWrite_r,
  output logic [CHANNELS-1:0][DSD_PACKET_BITS-1:0] dsdData_r,
  // channel status and infoframe fields
  output logic [3:0] csWordOut_r,
  output logic [3:0] csRateCode_r,
  output logic [3:0] infoRateCode_r,
  // master audio clock
  output logic mclkOut_r
);
  // chip reset: synchronised, so the release never races the clock
  logic chipMeta_r;
  logic chipSync_r;
  logic rst;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chipMeta_r <= 1'b1;
      chipSync_r <= 1'b1;
    end else begin
      chipMeta_r <= ~chipRstN;
      chipSync_r <= chipMeta_r;
    end
  end
  assign rst = sys_rst | chipSync_r;

  // pins
  logic [PIN_COUNT-1:0] pinLvl;
  logic [PIN_COUNT-1:0] pinRise;

  aicd_pin_sync #(.W(PIN_COUNT)) uPins (
    .clk(mclk),
    .rst(rst),
    .pinIn({dsdLeft3In, dsdRight3In, spdifIn, serDataIn, wordSelIn, bitClkIn, extMclkIn}),
    .level(pinLvl),
    .rise(pinRise)
  );

  logic mclkExtLvl;
  logic sckRise;
  logic wsLvl;
  logic [I2S_LINES-1:0] sdLvl;
  assign mclkExtLvl = pinLvl[0];
  assign sckRise = pinRise[1];
  assign wsLvl = pinLvl[2];
  assign sdLvl = pinLvl[6:3];

  // registers
  aicd_ctrl_type ctrl_r;
  logic [3:0] csIn_r;
  logic [7:0] mdiv_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= aicd_ctrl_type'(CTRL_RESET);
      csIn_r <= CSIN_RESET;
      mdiv_r <= MDIV_RESET;
    end else if (regWr) begin
      if (regAddr == ADDR_CTRL) begin
        ctrl_r <= aicd_ctrl_type'(regWrData[15:0]);
      end else if (regAddr == ADDR_CSIN) begin
        csIn_r <= regWrData[3:0];
      end else if (regAddr == ADDR_MDIV) begin
        mdiv_r <= regWrData[7:0];
      end
    end
  end

  // log2 of the decimation factor actually applied
  function automatic logic [1:0] decim_shift(input aicd_ctrl_type c);
    if (c.mode != MODE_I2S) return 2'h0;
    if (c.rate == RATE_64) return 2'h1;
    if (c.rate == RATE_128) return 2'h2;
    if (!c.dsEn) return 2'h0;
    if ((c.rate == RATE_96 || c.rate == RATE_88) && c.decim == DECIM_HALF) return 2'h1;
    if ((c.rate == RATE_192 || c.rate == RATE_176) && c.decim == DECIM_QUARTER) return 2'h2;
    return 2'h0;
  endfunction

  // master clock ratio against sample rate
  function automatic logic ratio_ok(input aicd_ctrl_type c);
    logic fastRate;
    logic midRate;
    fastRate = c.rate == RATE_176 || c.rate == RATE_192 || c.rate == RATE_128;
    midRate = c.rate == RATE_88 || c.rate == RATE_96 || c.rate == RATE_64;
    if (c.rate > RATE_192) return 1'b0;
    if (c.ratio == RATIO_512 || c.ratio == RATIO_768) return !fastRate;
    if (c.ratio == RATIO_1024 || c.ratio == RATIO_1152) return !fastRate && !midRate;
    return 1'b1;
  endfunction

  // valid bits in a 24-bit left-justified word; 0 keeps all bits
  function automatic logic [4:0] word_len(input logic [3:0] cs);
    logic [4:0] base;
    base = cs[0] ? 5'h14 : 5'h10;
    case (cs[3:1])
      3'h1: return base;
      3'h6: return base + 5'h01;
      3'h2: return base + 5'h02;
      3'h4: return base + 5'h03;
      3'h5: return base + 5'h04;
      default: return 5'h00;
    endcase
  endfunction

  logic [1:0] dShift;
  logic dsActive;
  logic twoChan;
  logic decimErr;
  logic [4:0] srcLen;
  logic [WORD_BITS-1:0] keepMask;

  assign dShift = decim_shift(ctrl_r);
  assign dsActive = dShift != 2'h0;
  assign twoChan = dsActive;
  assign decimErr = ctrl_r.dsEn && !dsActive;
  assign srcLen = word_len(csIn_r);
  // keep the source's valid bits, zero below them
  assign keepMask = (!dsActive || srcLen == 5'h00) ? '1 : ~({WORD_BITS{1'b1}} >> srcLen);

  // I2S capture, one shift register per line
  logic wsPrev_r;
  logic wordEnd;
  logic frameSide_r;
  logic [1:0] decimCnt_r;
  logic keepFrame;
  logic [I2S_LINES-1:0] pend_r;
  logic [I2S_LINES-1:0] pendSet;
  logic [I2S_LINES-1:0] pendClr;
  logic [I2S_LINES-1:0][WORD_BITS-1:0] hold_r;
  logic [CNT_W-1:0] frameCnt_r;
  logic i2sOn;

  assign i2sOn = ctrl_r.mode == MODE_I2S || ctrl_r.mode == MODE_HBR;
  assign wordEnd = i2sOn && sckRise && (wsLvl != wsPrev_r);
  assign keepFrame = (decimCnt_r & ((2'h1 << dShift) - 2'h1)) == 2'h0;

  for (genvar i = 0; i < I2S_LINES; i++) begin : gLine
    logic [WORD_BITS-2:0] shift_r;
    always_ff @(posedge mclk) begin
      if (rst) begin
        shift_r <= '0;
        hold_r[i] <= '0;
      end else if (i2sOn && sckRise) begin
        shift_r <= {shift_r[WORD_BITS-3:0], sdLvl[i]};
        if (wordEnd) begin
          hold_r[i] <= {shift_r, sdLvl[i]};
        end
      end
    end
    // only line 0 carries the two-channel stream while decimating
    assign pendSet[i] = wordEnd && keepFrame && (!twoChan || i == 0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wsPrev_r <= 1'b0;
      frameSide_r <= 1'b0;
      decimCnt_r <= '0;
      frameCnt_r <= '0;
    end else if (i2sOn && sckRise) begin
      wsPrev_r <= wsLvl;
      if (wordEnd) begin
        frameSide_r <= wsPrev_r;
        frameCnt_r <= frameCnt_r + 8'h01;
        if (wsPrev_r) begin
          decimCnt_r <= decimCnt_r + 2'h1;
        end
      end
    end
  end

  // emit one held word per cycle, lowest line first
  logic [1:0] pickLine;
  always_comb begin
    pickLine = 2'h0;
    pendClr = '0;
    for (int k = I2S_LINES - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pickLine = 2'(k);
      end
    end
    if (pend_r != '0) begin
      pendClr[pickLine] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_r <= '0;
      sample_r <= '0;
      sampleValid_r <= 1'b0;
    end else begin
      // a new word wins over the clear of the same slot
      pend_r <= (pend_r & ~pendClr) | pendSet;
      sampleValid_r <= pend_r != '0;
      if (pend_r != '0) begin
        sample_r.hbr <= ctrl_r.mode == MODE_HBR;
        sample_r.chan <= {pickLine, frameSide_r};
        sample_r.data <= hold_r[pickLine] & keepMask;
      end
    end
  end

  // one-bit audio: pins reused as left and right data
  logic dsdOn;
  logic [CHANNELS-1:0] dsdBits;
  logic [CHANNELS-1:0] packWr;
  logic [CHANNELS-1:0][DSD_PACKET_BITS-1:0] packData;

  assign dsdOn = ctrl_r.mode == MODE_DSD;
  // even channels left, odd channels right
  assign dsdBits = {pinLvl[8], pinLvl[9], pinLvl[6], pinLvl[7], pinLvl[4], pinLvl[5], pinLvl[2], pinLvl[3]};

  aicd_dsd_packer uPack (
    .clk(mclk),
    .rst(rst),
    .enable(dsdOn),
    .bitRise(sckRise),
    .bits(dsdBits),
    .wr_r(packWr),
    .data_r(packData)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      dsdWrite_r <= '0;
      dsdData_r <= '0;
    end else begin
      dsdWrite_r <= packWr;
      if (packWr != '0) begin
        dsdData_r <= packData;
      end
    end
  end

  // channel status and infoframe fields
  always_ff @(posedge mclk) begin
    if (rst) begin
      csWordOut_r <= '0;
      csRateCode_r <= '0;
      infoRateCode_r <= '0;
    end else begin
      if (dsActive) begin
        csWordOut_r <= {CS_FORCED_LEN, csIn_r[0]};
      end else begin
        csWordOut_r <= csIn_r;
      end
      csRateCode_r <= dsdOn ? 4'h0 : ctrl_r.rate;
      infoRateCode_r <= dsdOn ? ctrl_r.rate : 4'h0;
    end
  end

  // master clock: divided system clock unless an external one is selected
  logic [7:0] mdivCnt_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mdivCnt_r <= '0;
      mclkOut_r <= 1'b0;
    end else if (ctrl_r.mclkExt) begin
      mdivCnt_r <= '0;
      mclkOut_r <= mclkExtLvl;
    end else if (mdivCnt_r >= mdiv_r) begin
      mdivCnt_r <= '0;
      mclkOut_r <= ~mclkOut_r;
    end else begin
      mdivCnt_r <= mdivCnt_r + 8'h01;
    end
  end

  // register read, data in the following cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData_r <= '0;
    end else if (regRd) begin
      if (regAddr == ADDR_CTRL) begin
        regRdData_r <= {16'h0000, ctrl_r};
      end else if (regAddr == ADDR_CSIN) begin
        regRdData_r <= {28'h0000000, csIn_r};
      end else if (regAddr == ADDR_STATUS) begin
        regRdData_r <= {17'h00000, !ratio_ok(ctrl_r), decimErr, dsActive, csWordOut_r, frameCnt_r};
      end else if (regAddr == ADDR_MDIV) begin
        regRdData_r <= {24'h000000, mdiv_r};
      end else begin
        regRdData_r <= '0;
      end
    end else begin
      regRdData_r <= '0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  csForce_a: assert property (dsActive |=> csWordOut_r == {CS_FORCED_LEN, $past(csIn_r[0])})
    else $error("word length not forced while downsampling");
  csPass_a: assert property (!dsActive |=> csWordOut_r == $past(csIn_r))
    else $error("word length changed while downsampler off");
  rate64Decim_a: assert property (ctrl_r.mode == MODE_I2S && ctrl_r.rate == RATE_64 |-> dShift == 2'h1)
    else $error("64 kHz not halved");
  hbrNoDecim_a: assert property (ctrl_r.mode == MODE_HBR |-> !dsActive)
    else $error("decimation applied to high bit-rate stream");
  zeroFill_a: assert property (sampleValid_r && $past(dsActive) && $stable(csIn_r)
      |-> (sample_r.data & ~$past(keepMask)) == '0)
    else $error("low bits not zero after widening");
  twoChanLine_a: assert property (sampleValid_r && $past(twoChan) |-> sample_r.chan[2:1] == 2'h0)
    else $error("decimated stream left line 0");
  dsdMode_a: assert property (dsdWrite_r != '0 |-> $past(dsdOn, 2))
    else $error("one-bit packet outside one-bit mode");
  infoRate_a: assert property (dsdOn |=> csRateCode_r == 4'h0 && infoRateCode_r == $past(ctrl_r.rate))
    else $error("one-bit rate not carried in infoframe");
  mclkGen_a: assert property (!ctrl_r.mclkExt && $stable(ctrl_r) && $stable(mdiv_r)
      |-> ##[1:258] $changed(mclkOut_r))
    else $error("internal master clock stalled");
  readLat_a: assert property (regRd && regAddr == ADDR_MDIV && !regWr |=> regRdData_r == {24'h000000, mdiv_r})
    else $error("register read data wrong");
endmodule
`default_nettype wire

// [bench/aicd_source_model.sv]
/*
  Behavioural upstream audio source: I2S frames on four lines and one-bit audio bursts.
  Assumes the capture block samples these pins with its own clock; the bench calls the tasks.
*/
`timescale 1ns/100ps
`default_nettype none
module aicd_source_model
  import aicd_pkg::*;
(
  // serial clock and word select
  output logic bitClk,
  output logic wordSel,
  // data pins
  output logic [I2S_LINES-1:0] serData,
  output logic spdifPin,
  output logic right3,
  output logic left3
);
  // faster than 64 x 44.1 kHz to keep runs short; clock stands still between bursts
  localparam real HALF_NS = 62.5;
  // small start skew keeps every pin change off the system clock edges
  localparam real SKEW_NS = 0.3;
  initial begin
    bitClk = 1'b0;
    wordSel = 1'b0;
    serData = 4'h0;
    spdifPin = 1'b0;
    right3 = 1'b0;
    left3 = 1'b0;
  end
  // released lines show the inverse of their last value, never a stale copy
  task automatic release_lines();
    wordSel = ~wordSel;
    serData = ~serData;
    spdifPin = ~spdifPin;
    right3 = ~right3;
    left3 = ~left3;
  endtask
  task automatic clock_bit();
    #(HALF_NS) bitClk = 1'b1;
    #(HALF_NS) bitClk = 1'b0;
  endtask
  // word select turns with the last bit of each word; four lines share clock and select
  task automatic send_i2s(input logic [WORD_BITS-1:0] w [CHANNELS], input int frames);
    #(SKEW_NS);
    for (int f = 0; f < frames; f++) begin
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < WORD_BITS; k++) begin
          wordSel = (k == WORD_BITS - 1) ? ~s[0] : s[0];
          for (int l = 0; l < I2S_LINES; l++) begin
            serData[l] = w[2 * l + s][WORD_BITS - 1 - k];
          end
          clock_bit();
        end
      end
    end
    release_lines();
  endtask
  // nine pins, eight channels, data steady across each clock rise
  task automatic send_dsd(input logic [DSD_PACKET_BITS-1:0] p [CHANNELS]);
    #(SKEW_NS);
    for (int k = DSD_PACKET_BITS - 1; k >= 0; k--) begin
      serData[0] = p[0][k];
      wordSel = p[1][k];
      serData[2] = p[2][k];
      serData[1] = p[3][k];
      spdifPin = p[4][k];
      serData[3] = p[5][k];
      left3 = p[6][k];
      right3 = p[7][k];
      clock_bit();
    end
    release_lines();
  endtask
endmodule
`default_nettype wire

// [bench/tb_audio_input_capture_downsampler.sv]
/*
  Self-checking bench for the audio capture block: registers, I2S, decimation, one-bit audio.
  Assumes the source model drives the audio pins and the bench owns the register port.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_audio_input_capture_downsampler
  import aicd_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipRstN = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic extMclkIn = 1'b0;
  logic [31:0] regRdData_r;
  aicd_sample_type sample_r;
  logic sampleValid_r;
  logic [CHANNELS-1:0] dsdWrite_r;
  logic [CHANNELS-1:0][DSD_PACKET_BITS-1:0] dsdData_r;
  logic [3:0] csWordOut_r;
  logic [3:0] csRateCode_r;
  logic [3:0] infoRateCode_r;
  logic mclkOut_r;
  logic bitClkIn, wordSelIn, spdifIn, dsdRight3In, dsdLeft3In;
  logic [I2S_LINES-1:0] serDataIn;
  int n_mismatch = 0;
  int total_checks = 0;
  int dsdCount = 0;
  int togCnt = 0;
  int extDiv = 0;
  logic mclkOutQ = 1'b0;
  logic [CHANNELS-1:0] dsdLanes = '0;
  aicd_sample_type seen[$];
  logic [DSD_PACKET_BITS-1:0] dsdSeen [CHANNELS];
  logic [WORD_BITS-1:0] words [CHANNELS];
  logic [DSD_PACKET_BITS-1:0] pkts [CHANNELS];
  logic [31:0] rdv;
  logic [7:0] rAddr [4] = '{ADDR_CTRL, ADDR_CSIN, ADDR_MDIV, 8'h10};
  logic [31:0] rExp [4] = '{{16'h0, CTRL_RESET}, {28'h0, CSIN_RESET}, {24'h0, MDIV_RESET}, 32'h0};
  aicd_rate_type decRate [6] = '{RATE_96, RATE_88, RATE_192, RATE_176, RATE_64, RATE_128};
  int decFac [6] = '{2, 2, 4, 4, 2, 4};
  aicd_rate_type qRate [5] = '{RATE_192, RATE_96, RATE_96, RATE_48, RATE_176};
  aicd_ratio_type qRatio [5] = '{RATIO_512, RATIO_768, RATIO_1024, RATIO_1152, RATIO_384};
  logic qErr [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #4 mclk = ~mclk;

  aicd_capture dut (.mclk(mclk), .sys_rst(sys_rst), .chipRstN(chipRstN), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r),
    .extMclkIn(extMclkIn), .bitClkIn(bitClkIn), .wordSelIn(wordSelIn), .serDataIn(serDataIn),
    .spdifIn(spdifIn), .dsdRight3In(dsdRight3In), .dsdLeft3In(dsdLeft3In), .sample_r(sample_r),
    .sampleValid_r(sampleValid_r), .dsdWrite_r(dsdWrite_r), .dsdData_r(dsdData_r),
    .csWordOut_r(csWordOut_r), .csRateCode_r(csRateCode_r), .infoRateCode_r(infoRateCode_r),
    .mclkOut_r(mclkOut_r));
  aicd_source_model src (.bitClk(bitClkIn), .wordSel(wordSelIn), .serData(serDataIn),
    .spdifPin(spdifIn), .right3(dsdRight3In), .left3(dsdLeft3In));

  // external master clock, toggling every five system cycles
  always @(posedge mclk) begin
    extDiv <= (extDiv == 4) ? 0 : extDiv + 1;
    if (extDiv == 4) extMclkIn <= ~extMclkIn;
  end
  always @(posedge mclk) begin
    if (sampleValid_r === 1'b1) seen.push_back(sample_r);
    if (dsdWrite_r !== '0) begin
      dsdCount++;
      dsdLanes = dsdWrite_r;
      for (int c = 0; c < CHANNELS; c++) dsdSeen[c] = dsdData_r[c];
    end
    mclkOutQ <= mclkOut_r;
    if (mclkOut_r !== mclkOutQ) togCnt++;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdData_r;
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  function automatic logic [31:0] ctrl_word(input logic en, input aicd_decim_type dc, input aicd_mode_type md,
                                            input aicd_ratio_type ra, input aicd_rate_type rt, input logic ext);
    return {16'h0000, 3'h0, rt, ra, ext, md, dc, en};
  endfunction
  function automatic logic [63:0] found(input int c, input logic hb);
    foreach (seen[i]) if (seen[i].chan === 3'(c) && seen[i].data === words[c] && seen[i].hbr === hb) return 1;
    return 0;
  endfunction
  // samples off line 0, or with low bits left set below a 20-bit source word
  function automatic logic [63:0] bad_count();
    logic [63:0] n;
    n = '0;
    foreach (seen[i]) if (seen[i].chan[2:1] !== 2'h0 || seen[i].data[3:0] !== 4'h0) n++;
    return n;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    wr(8'h10, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      rd(rAddr[i], rdv);
      chk("reset value", rExp[i], rdv);
    end
    for (int v = 0; v < 16; v++) begin
      wr(ADDR_CSIN, 32'(v));
      wr(ADDR_CTRL, ctrl_word(1'b0, DECIM_NONE, MODE_I2S, RATIO_256, RATE_48, 1'b0));
      settle();
      chk("cs passthrough", 64'(v), csWordOut_r);
      wr(ADDR_CTRL, ctrl_word(1'b1, DECIM_HALF, MODE_I2S, RATIO_256, RATE_96, 1'b0));
      settle();
      chk("cs forced", {60'h0, 3'h5, v[0]}, csWordOut_r);
    end
    for (int c = 0; c < CHANNELS; c++) words[c] = 24'hC35A00 + 24'(c * 17 + 1);
    wr(ADDR_CSIN, 32'h3);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, ctrl_word(1'b0, DECIM_NONE, m ? MODE_HBR : MODE_I2S, RATIO_256, RATE_48, 1'b0));
      seen.delete();
      src.send_i2s(words, 3);
      repeat (20) @(posedge mclk);
      for (int c = 0; c < CHANNELS; c++) chk("i2s word", 1, found(c, m[0]));
    end
    // each decimation case covers a supported conversion or a forced 64/128 kHz rate
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CTRL, ctrl_word(i < 4, i > 3 ? DECIM_NONE : decFac[i] == 2 ? DECIM_HALF : DECIM_QUARTER,
                              MODE_I2S, RATIO_256, decRate[i], 1'b0));
      seen.delete();
      src.send_i2s(words, 4);
      repeat (20) @(posedge mclk);
      chk("decimated kept", 8 / decFac[i], seen.size());
      chk("decimated bad", 0, bad_count());
      chk("decimated cs", 4'hB, csWordOut_r);
      rd(ADDR_STATUS, rdv);
      chk("decimated status", 2'h1, rdv[13:12]);
    end
    wr(ADDR_CTRL, ctrl_word(1'b1, DECIM_HALF, MODE_I2S, RATIO_256, RATE_48, 1'b0));
    rd(ADDR_STATUS, rdv);
    chk("refused status", 2'h2, rdv[13:12]);
    chk("refused cs", 4'h3, csWordOut_r);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL, ctrl_word(1'b0, DECIM_NONE, MODE_I2S, qRatio[i], qRate[i], 1'b0));
      rd(ADDR_STATUS, rdv);
      chk("ratio flag", qErr[i], rdv[14]);
    end
    for (int c = 0; c < CHANNELS; c++) pkts[c] = {7{8'h96 ^ 8'(c * 37)}} ^ 56'h0123456789ABCD;
    wr(ADDR_CTRL, ctrl_word(1'b0, DECIM_NONE, MODE_DSD, RATIO_256, RATE_44, 1'b0));
    dsdCount = 0;
    src.send_dsd(pkts);
    for (int i = 0; i < 50 && dsdCount == 0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    chk("dsd writes", 1, dsdCount);
    chk("dsd lanes", 8'hFF, dsdLanes);
    for (int c = 0; c < CHANNELS; c++) chk("dsd packet", pkts[c], dsdSeen[c]);
    chk("cs rate code", 0, csRateCode_r);
    chk("info rate code", RATE_44, infoRateCode_r);
    wr(ADDR_MDIV, 32'h3);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_CTRL, ctrl_word(1'b0, DECIM_NONE, MODE_I2S, RATIO_256, RATE_48, e[0]));
      repeat (10) @(posedge mclk);
      #1 togCnt = 0;
      repeat (100) @(posedge mclk);
      #1 chk("mclk toggles", e ? 20 : 25, togCnt);
    end
    wr(ADDR_CTRL, ctrl_word(1'b1, DECIM_HALF, MODE_HBR, RATIO_256, RATE_64, 1'b0));
    chipRstN <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk("cs in chip reset", 0, csWordOut_r);
    chipRstN <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(ADDR_CTRL, rdv);
    chk("ctrl after chip reset", {16'h0, CTRL_RESET}, rdv);
    rd(ADDR_MDIV, rdv);
    chk("mdiv after chip reset", {24'h0, MDIV_RESET}, rdv);
    close_out();
  end
endmodule
`default_nettype wire
